// *** logic/gpf_port.sv ***
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module gpf_port
    import gpf_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [gpf_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [gpf_pkg::AXI_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [gpf_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [gpf_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [gpf_pkg::PORT_W-1:0] pin_in,
    output logic [gpf_pkg::PORT_W-1:0] pin_out,
    output logic [gpf_pkg::PORT_W-1:0] pin_oe,
    input wire logic debug_select_input,
    output logic [gpf_pkg::PORT_W-1:0] periph_pin_level,
    input wire logic timer0_match2,
    input wire logic timer1_match2,
    input wire logic timer1_match3,
    input wire logic pulse_width_output_5,
    input wire logic dbg_tdo,
    input wire logic dbg_tdo_oe
);
    import gpf_pkg::*;

    logic [31:0] pin_meta;
    logic [31:0] pin_sync;
    logic dbg_meta;
    logic dbg_sync;
    logic dbg_latched;
    logic next_dbg_latched;
    logic [31:0] out_reg;
    logic [31:0] next_out_reg;
    logic [31:0] dir;
    logic [31:0] next_dir;
    logic [31:0] upper_sel;
    logic [31:0] next_upper_sel;
    logic aw_held;
    logic next_aw_held;
    logic w_held;
    logic next_w_held;
    logic [31:0] aw_addr;
    logic [31:0] next_aw_addr;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0] w_strb;
    logic [3:0] next_w_strb;
    logic bvalid;
    logic next_bvalid;
    logic [1:0] bresp;
    logic [1:0] next_bresp;
    logic rvalid;
    logic next_rvalid;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [1:0] rresp;
    logic [1:0] next_rresp;
    logic wr_fire;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic [31:0] alt1_out;
    logic [31:0] alt1_oe;
    logic [31:0] alt2_out;
    logic [31:0] alt2_oe;
    logic [31:0] gpio_mask;
    logic [31:0] next_pin_out;
    logic [31:0] next_pin_oe;

    // Pins and the debug strap pass two flops before any logic reads them.
    always_ff @(posedge aclk)
    begin
        pin_meta <= pin_in;
        pin_sync <= pin_meta;
        dbg_meta <= debug_select_input;
        dbg_sync <= dbg_meta;
    end

    assign periph_pin_level = pin_sync;

    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign wr_fire = aw_held && w_held;
    assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    assign wbits = w_data & wmask;

    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_out_reg = out_reg;
        next_dir = dir;
        next_upper_sel = upper_sel;
        next_dbg_latched = dbg_latched;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            // Writes apply one at a time, so the later of set and clear wins.
            unique case (aw_addr)
                PIN_LEVEL_ADDR: next_out_reg = (out_reg & ~wmask) | wbits;
                OUT_SET_ADDR: next_out_reg = out_reg | wbits;
                OUT_CLR_ADDR: next_out_reg = out_reg & ~wbits;
                DIR_ADDR: next_dir = (dir & ~wmask) | wbits;
                UPPER_SEL_ADDR: next_upper_sel = (upper_sel & ~wmask) | wbits;
                default: next_bresp = RESP_SLVERR;
            endcase
        end
        if (bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            unique case (s_axi_araddr)
                PIN_LEVEL_ADDR: next_rdata = pin_sync;
                OUT_SET_ADDR: next_rdata = out_reg;
                OUT_CLR_ADDR: next_rdata = 32'h0000_0000;
                DIR_ADDR: next_rdata = dir;
                UPPER_SEL_ADDR: next_rdata = upper_sel;
                default:
                begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
        // The strap is caught while reset is held.
        if (!aresetn)
        begin
            next_dbg_latched = dbg_sync;
        end
    end

    always_ff @(posedge aclk)
    begin
        dbg_latched <= next_dbg_latched;
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
            out_reg <= OUT_RESET;
            dir <= DIR_RESET;
            upper_sel <= UPPER_SEL_RESET;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            out_reg <= next_out_reg;
            dir <= next_dir;
            upper_sel <= next_upper_sel;
        end
    end

    // Peripheral sources per pin; bit 31 enable follows the debug unit.
    assign alt1_out = {dbg_tdo, 9'h000, pulse_width_output_5, timer1_match3,
                       timer1_match2, 3'h0, 16'h0000};
    assign alt1_oe = ALT1_FIXED_OE | {dbg_tdo_oe, 31'h0000_0000};
    assign alt2_out = {15'h0000, timer0_match2, 16'h0000};
    assign alt2_oe = ALT2_VALID;

    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++)
        begin : g_pin
            logic [1:0] fsel;
            if (gi < UPPER_LO_BIT)
            begin : g_low
                assign fsel = SEL_PRIMARY;
            end
            else if (gi < DBG_GATE_LO_BIT)
            begin : g_free
                assign fsel = upper_sel[2*(gi-UPPER_LO_BIT) +: 2];
            end
            else
            begin : g_gated
                assign fsel = dbg_latched ? SEL_PRIMARY
                                          : upper_sel[2*(gi-UPPER_LO_BIT) +: 2];
            end
            assign gpio_mask[gi] = (fsel == SEL_PRIMARY);
            always_comb
            begin
                next_pin_out[gi] = 1'b0;
                next_pin_oe[gi] = 1'b0;
                unique case (fsel)
                    SEL_PRIMARY:
                    begin
                        next_pin_out[gi] = out_reg[gi];
                        next_pin_oe[gi] = dir[gi];
                    end
                    SEL_ALT1:
                    begin
                        next_pin_out[gi] = alt1_out[gi] & ALT1_VALID[gi];
                        next_pin_oe[gi] = alt1_oe[gi] & ALT1_VALID[gi];
                    end
                    SEL_ALT2:
                    begin
                        next_pin_out[gi] = alt2_out[gi] & ALT2_VALID[gi];
                        next_pin_oe[gi] = alt2_oe[gi];
                    end
                    // A reserved code leaves the pin released, as the defaults above set it.
                    SEL_RSVD: next_pin_oe[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out <= 32'h0000_0000;
            pin_oe <= 32'h0000_0000;
        end
        else
        begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sel_reset_a: assert property ($rose(aresetn) |-> upper_sel == 32'h0 && dir == 32'h0)
        else $error("select or direction not zero after reset");
    set_write_a: assert property (wr_fire && aw_addr == OUT_SET_ADDR
        |=> out_reg == ($past(out_reg) | $past(wbits)))
        else $error("set write wrong");
    clr_write_a: assert property (wr_fire && aw_addr == OUT_CLR_ADDR
        |=> out_reg == ($past(out_reg) & ~$past(wbits)))
        else $error("clear write wrong");
    pin_write_a: assert property (wr_fire && aw_addr == PIN_LEVEL_ADDR && w_strb == 4'hF
        |=> out_reg == $past(w_data))
        else $error("pin level write did not load output");
    gpio_drive_a: assert property (1'b1 |=> (pin_oe & $past(gpio_mask)) == ($past(dir) & $past(gpio_mask)))
        else $error("gpio pin enable not from direction");
    dbg_gate_a: assert property (dbg_latched |=> pin_oe[31:17] == $past(dir[31:17]))
        else $error("debug gate ignored");
    level_read_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == PIN_LEVEL_ADDR |=> rvalid && rdata == $past(pin_sync))
        else $error("pin level read wrong");
    set_read_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == OUT_SET_ADDR |=> rdata == $past(out_reg))
        else $error("set register read wrong");
    resp_hold_a: assert property (bvalid && !s_axi_bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    alt_drive_a: assert property (upper_sel[11:10] == SEL_ALT1 && !dbg_latched
        ##1 $stable(upper_sel) |=> pin_oe[21] && pin_out[21] == $past(pulse_width_output_5))
        else $error("pulse output not routed");

    set_clr_c: cover property (wr_fire && aw_addr == OUT_SET_ADDR
        ##[1:20] wr_fire && aw_addr == OUT_CLR_ADDR);
    alt_sel_c: cover property (wr_fire && aw_addr == UPPER_SEL_ADDR ##1 !gpio_mask[16]);
    read_c: cover property (rvalid && s_axi_rready);
    bad_addr_c: cover property (bvalid && bresp == RESP_SLVERR);
endmodule : gpf_port
`default_nettype wire

// *** logic/gpf_pkg.sv ***
`default_nettype none
package gpf_pkg;
    localparam int PORT_W = 32;
    localparam int AXI_AW = 32;
    localparam int AXI_DW = 32;
    localparam logic [31:0] PIN_LEVEL_ADDR = 32'hE002_8000;
    localparam logic [31:0] OUT_SET_ADDR = 32'hE002_8004;
    localparam logic [31:0] DIR_ADDR = 32'hE002_8008;
    localparam logic [31:0] OUT_CLR_ADDR = 32'hE002_800C;
    localparam logic [31:0] UPPER_SEL_ADDR = 32'hE002_C004;
    localparam logic [31:0] OUT_RESET = 32'h0000_0000;
    localparam logic [31:0] DIR_RESET = 32'h0000_0000;
    localparam logic [31:0] UPPER_SEL_RESET = 32'h0000_0000;
    localparam logic [1:0] SEL_PRIMARY = 2'h0;
    localparam logic [1:0] SEL_ALT1 = 2'h1;
    localparam logic [1:0] SEL_ALT2 = 2'h2;
    localparam logic [1:0] SEL_RSVD = 2'h3;
    localparam int UPPER_LO_BIT = 16;
    localparam int DBG_GATE_LO_BIT = 17;
    localparam logic [31:0] ALT1_VALID = 32'hF83F_0000;
    localparam logic [31:0] ALT2_VALID = 32'h0001_0000;
    localparam logic [31:0] ALT1_FIXED_OE = 32'h0038_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpf_pkg
`default_nettype wire

// *** dv/gpf_pins.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pads of the port: a driven pad shows the device's level, a released pad shows the
// level that the outside world applies, which the bench changes from test to test.
module gpf_pins
(
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] ext_level,
    output logic [31:0] pin_in
);
    assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : gpf_pins
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    import gpf_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, dbg = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, pin_in, pin_out, pin_oe, lvl;
    logic [31:0] ext = 0, sel_m, dir_m, out_m, v;
    logic [1:0] bresp, rresp, r;
    logic [5:0] per = 0;
    logic dbg_m;
    int n_mismatch = 0, samples_checked = 0, seed = 38;
    always #10 aclk = ~aclk;
    gpf_port uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .debug_select_input(dbg), .periph_pin_level(lvl),
        .timer0_match2(per[0]), .timer1_match2(per[1]), .timer1_match3(per[2]),
        .pulse_width_output_5(per[3]), .dbg_tdo(per[4]), .dbg_tdo_oe(per[5]));
    gpf_pins pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] rs);
        bit got;
        got = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!got)
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) begin rs = bresp; bready <= 0; got = 1; end
        end
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
        bit got;
        got = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        while (!got)
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) begin d = rdata; rs = rresp; rready <= 0; got = 1; end
        end
    endtask : rd
    // Writes a mapped register and keeps the bench's own copy of the port state.
    task automatic wm(input logic [31:0] a, input logic [31:0] d);
        wr(a, d, r);
        `CHK("bresp", RESP_OKAY, r)
        case (a)
            PIN_LEVEL_ADDR: out_m = d;
            OUT_SET_ADDR: out_m = out_m | d;
            OUT_CLR_ADDR: out_m = out_m & ~d;
            DIR_ADDR: dir_m = d;
            default: sel_m = d;
        endcase
    endtask : wm
    task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
        rd(a, v, r);
        `CHK(n, e, v)
    endtask : rchk
    function automatic logic [63:0] exp_pins(logic [31:0] sel, dir, out, logic dg,
        logic [5:0] p);
        logic [31:0] oe, po;
        logic [1:0] c;
        oe = dir;
        po = out;
        for (int i = 16; i < 32; i++)
        begin
            c = (dg && i > 16) ? 2'h0 : sel[2*(i-16)+:2];
            if (c != SEL_PRIMARY)
            begin
                oe[i] = 0;
                if (c == SEL_ALT1 && i >= 19 && i <= 21) begin oe[i] = 1; po[i] = p[i-18]; end
                if (c == SEL_ALT1 && i == 31) begin oe[i] = p[5]; po[i] = p[4]; end
                if (c == SEL_ALT2 && i == 16) begin oe[i] = 1; po[i] = p[0]; end
            end
        end
        return {oe, po & oe};
    endfunction : exp_pins
    // Lets register, pad and level updates land, then checks pads and level readback.
    task automatic pins_ok;
        logic [63:0] e;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        e = exp_pins(sel_m, dir_m, out_m, dbg_m, per);
        `CHK("pin_oe", e[63:32], pin_oe)
        `CHK("pin_out", e[31:0], pin_out & pin_oe)
        `CHK("pin_lvl", e[31:0] | (ext & ~e[63:32]), lvl)
        rchk("level", PIN_LEVEL_ADDR, e[31:0] | (ext & ~e[63:32]));
    endtask : pins_ok
    task automatic rst(input logic d);
        @(posedge aclk);
        aresetn <= 0;
        dbg <= d;
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        dbg_m = d; sel_m = 0; dir_m = 0; out_m = 0;
    endtask : rst
    initial
    begin
        #(20 * 50000);
        n_mismatch++;
        test_done();
    end
    initial
    begin
        rst(0);
        rchk("set_rst", OUT_SET_ADDR, OUT_RESET);
        rchk("dir_rst", DIR_ADDR, DIR_RESET);
        rchk("sel_rst", UPPER_SEL_ADDR, UPPER_SEL_RESET);
        rchk("clr_rd", OUT_CLR_ADDR, 32'h0000_0000);
        ext <= $random(seed);
        pins_ok();
        $display("test reset done");
        wm(DIR_ADDR, 32'hFFFF_FFFF);
        wm(OUT_SET_ADDR, 32'h0000_0080);
        wm(OUT_CLR_ADDR, 32'h0000_0080);
        rchk("set_clr", OUT_SET_ADDR, 32'h0000_0000);
        wm(OUT_SET_ADDR, 32'h0000_0080);
        rchk("clr_set", OUT_SET_ADDR, 32'h0000_0080);
        pins_ok();
        $display("test order done");
        for (int k = 0; k < 4; k++)
        begin
            per <= $random(seed);
            wm(UPPER_SEL_ADDR, {16'h8000, 10'h150, 4'h0, k[1:0]});
            wm(OUT_SET_ADDR, 32'hFFFF_FFFF);
            pins_ok();
        end
        $display("test select done");
        for (int k = 0; k < 40; k++)
        begin
            ext <= $random(seed);
            per <= $random(seed);
            v = $random(seed);
            case ($unsigned($random(seed)) % 5)
                0: wm(PIN_LEVEL_ADDR, v);
                1: wm(OUT_SET_ADDR, v);
                2: wm(OUT_CLR_ADDR, v);
                3: wm(DIR_ADDR, v);
                default: wm(UPPER_SEL_ADDR, v);
            endcase
            rchk("set_rd", OUT_SET_ADDR, out_m);
            pins_ok();
        end
        $display("test random done");
        wr(32'hE002_8010, 32'hFFFF_FFFF, r);
        `CHK("unm_wr", RESP_SLVERR, r)
        rd(32'hE002_C008, v, r);
        `CHK("unm_rd", RESP_SLVERR, r)
        `CHK("unm_dat", 32'h0000_0000, v)
        $display("test unmapped done");
        rst(1);
        wm(DIR_ADDR, 32'h0000_0000);
        wm(UPPER_SEL_ADDR, 32'h5555_5542);
        rchk("sel_keep", UPPER_SEL_ADDR, 32'h5555_5542);
        per <= 6'h3F;
        pins_ok();
        $display("test strap done");
        test_done();
    end
endmodule : tb
`default_nettype wire
